// ---- common/pic_pkg.sv ----
// package: constants, types and register map of the interrupt controller
// How it works
// - four enable bits, inputs three to six
// - per-input polarity picks rising or falling
// - edges latched, short pulses never lost
// - latched edge requests its handler once no other handler runs
// - interrupt role clears counter and measuring
// - source eighteen fires every programmed milliseconds
// - timer counts clock, independent of scans
// - timer request waits while another handler runs, counting goes on
// - source seventeen fires on power loss
// - error trap: display, handler, no halt
// - undefined handler redirects to error trap
// - pairs three-four, five-six form counters
// - counter define also enables measuring
// - measure command after define stops counting
// - measure alone never enables counting
// - measuring pins synchronised for ten kilohertz
// - counter compare request joins arbitration
package pic_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [7:0] SRC_PWR = 8'h11;
  localparam logic [7:0] SRC_TICK = 8'h12;
  localparam logic [7:0] SRC_TRAP = 8'h64;
  localparam logic [7:0] SRC_IN3 = 8'h03;
  localparam logic [7:0] SRC_CNT1 = 8'h21;
  // register offsets
  localparam logic [3:0] REG_INCFG = 4'h0;
  localparam logic [3:0] REG_FUNC = 4'h1;
  localparam logic [3:0] REG_TICK = 4'h2;
  localparam logic [3:0] REG_BIND = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  localparam logic [3:0] REG_CMD = 4'h6;
  localparam logic [3:0] REG_ERR = 4'h7;
  // field positions
  localparam int INCFG_EN_LSB = 0;
  localparam int INCFG_POL_LSB = 4;
  localparam int CMD_DEF1 = 0;
  localparam int CMD_DEF2 = 1;
  localparam int CMD_MEAS_LSB = 2;
  localparam int BIND_PWR = 4;
  localparam int BIND_TICK = 5;
  localparam int BIND_TRAP = 6;
  localparam int BIND_CNT_LSB = 7;
  localparam int ST_REQ = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_TICKLOST = 2;
  localparam int ST_PWR = 3;
  // reset values
  localparam logic [15:0] TICK_RST = 16'h0000;
  localparam logic [3:0] STAT_RST = 4'h0;
  typedef enum logic [2:0] {
    PIC_IDLE = 3'b001,
    PIC_OFFER = 3'b010,
    PIC_BUSY = 3'b100
  } pic_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pic_bus_s;
  typedef struct packed {
    logic [3:0] quadEn;
    logic [3:0] measEn;
  } pic_func_s;
endpackage

// ---- hdl/pic_interrupt_controller.sv ----
// interrupt arbitration, edge capture, periodic timer and pin function select
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module pic_interrupt_controller
  import pic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire pic_bus_s bus,
  output logic [15:0] rdData,
  // field pins and events
  input wire logic [3:0] pinIn,
  input wire logic powerLossN,
  input wire logic runError,
  input wire logic [1:0] cntMatch,
  // core handshake
  output logic reqValid,
  output logic [7:0] reqSource,
  input wire logic reqAck,
  input wire logic reqDone,
  // function select and error display
  output pic_func_s pinFunc,
  output logic errShow,
  output logic errLed,
  output logic cpuHalt,
  output logic irq
);
  logic [3:0] pinS1_reg, pinS2_reg, pinPrev_reg;
  logic pwrS1_reg, pwrS2_reg, pwrPrev_reg;
  logic [7:0] inCfg_reg;
  logic [15:0] tickMs_reg;
  logic [8:0] bind_reg;
  logic [3:0] stat_reg, mask_reg;
  logic [3:0] pendIn_reg;
  logic [1:0] pendCnt_reg;
  logic pendPwr_reg, pendTick_reg, pendTrap_reg;
  logic [16:0] msDiv_reg;
  logic [15:0] msCnt_reg;
  logic tickEv;
  pic_state_e state_reg;
  logic [7:0] grantSrc;
  logic grantAny, grantUnbound;
  logic [15:0] rdData_next;

  function automatic logic hit(input pic_bus_s b, input logic [3:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  // pins are asynchronous, two stages before use
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1_reg <= 4'h0;
      pinS2_reg <= 4'h0;
      pinPrev_reg <= 4'h0;
      pwrS1_reg <= 1'b1;
      pwrS2_reg <= 1'b1;
      pwrPrev_reg <= 1'b1;
    end else begin
      pinS1_reg <= pinIn;
      pinS2_reg <= pinS1_reg;
      pinPrev_reg <= pinS2_reg;
      pwrS1_reg <= powerLossN;
      pwrS2_reg <= pwrS1_reg;
      pwrPrev_reg <= pwrS2_reg;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      inCfg_reg <= 8'h00;
      tickMs_reg <= TICK_RST;
      bind_reg <= 9'h000;
      mask_reg <= 4'h0;
    end else begin
      if (hit(bus, REG_INCFG)) inCfg_reg <= bus.wdata[7:0];
      if (hit(bus, REG_TICK)) tickMs_reg <= bus.wdata;
      if (hit(bus, REG_BIND)) bind_reg <= bus.wdata[8:0];
      if (hit(bus, REG_MASK)) mask_reg <= bus.wdata[3:0];
    end
  end

  // pin function select, counter define per pair, measure and interrupt role per pin
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinFunc <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hit(bus, REG_CMD) && bus.wdata[CMD_DEF1 + c]) begin
          pinFunc.quadEn[2*c +: 2] <= 2'b11;
          pinFunc.measEn[2*c +: 2] <= 2'b11;
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (hit(bus, REG_CMD) && bus.wdata[CMD_MEAS_LSB + i]) begin
          pinFunc.measEn[i] <= 1'b1;
          pinFunc.quadEn[i & 2] <= 1'b0;
          pinFunc.quadEn[(i & 2) + 1] <= 1'b0;
        end
        if (inCfg_reg[INCFG_EN_LSB + i]) begin
          pinFunc.quadEn[i] <= 1'b0;
          pinFunc.measEn[i] <= 1'b0;
        end
      end
    end
  end

  // millisecond enable and period counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      msDiv_reg <= '0;
      msCnt_reg <= '0;
    end else if (!bind_reg[BIND_TICK] || tickMs_reg == 16'h0000) begin
      msDiv_reg <= '0;
      msCnt_reg <= '0;
    end else if (msDiv_reg == 17'(MS_CYCLES - 1)) begin
      msDiv_reg <= '0;
      msCnt_reg <= (msCnt_reg == tickMs_reg - 16'h0001) ? 16'h0000 : msCnt_reg + 16'h0001;
    end else begin
      msDiv_reg <= msDiv_reg + 17'h0_0001;
    end
  end
  assign tickEv = bind_reg[BIND_TICK] && tickMs_reg != 16'h0000 &&
                  msDiv_reg == 17'(MS_CYCLES - 1) && msCnt_reg == tickMs_reg - 16'h0001;

  // priority pick: power, trap, inputs, counters, then timer
  always_comb begin
    grantAny = 1'b1;
    grantSrc = SRC_TICK;
    grantUnbound = 1'b0;
    if (pendPwr_reg) grantSrc = SRC_PWR;
    else if (pendTrap_reg) grantSrc = SRC_TRAP;
    else if (|pendIn_reg) begin
      grantSrc = SRC_IN3;
      for (int i = 3; i >= 0; i--)
        if (pendIn_reg[i]) grantSrc = SRC_IN3 + 8'(i);
    end else if (|pendCnt_reg) grantSrc = pendCnt_reg[0] ? SRC_CNT1 : SRC_CNT1 + 8'h01;
    else if (pendTick_reg) grantSrc = SRC_TICK;
    else grantAny = 1'b0;
    if (grantSrc == SRC_PWR) grantUnbound = !bind_reg[BIND_PWR];
    else if (grantSrc == SRC_TICK) grantUnbound = 1'b0;
    else if (grantSrc == SRC_TRAP) grantUnbound = 1'b0;
    else if (grantSrc >= SRC_CNT1) grantUnbound = !bind_reg[BIND_CNT_LSB + int'(grantSrc[0] == 1'b0)];
    else grantUnbound = !bind_reg[grantSrc[1:0] - 2'd3];
  end

  // pending flags, edge capture wins over the grant clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pendIn_reg <= 4'h0;
      pendCnt_reg <= 2'b00;
      pendPwr_reg <= 1'b0;
      pendTick_reg <= 1'b0;
      pendTrap_reg <= 1'b0;
    end else begin
      logic take;
      take = state_reg == PIC_IDLE && grantAny;
      for (int i = 0; i < 4; i++) begin
        if (take && grantSrc == SRC_IN3 + 8'(i)) pendIn_reg[i] <= 1'b0;
        if (inCfg_reg[INCFG_EN_LSB + i] && (inCfg_reg[INCFG_POL_LSB + i] ?
            (pinS2_reg[i] && !pinPrev_reg[i]) : (!pinS2_reg[i] && pinPrev_reg[i])))
          pendIn_reg[i] <= 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
        if (take && grantSrc == SRC_CNT1 + 8'(c)) pendCnt_reg[c] <= 1'b0;
        if (cntMatch[c] && pinFunc.quadEn[2*c]) pendCnt_reg[c] <= 1'b1;
      end
      if (take && grantSrc == SRC_PWR) pendPwr_reg <= 1'b0;
      if (!pwrS2_reg && pwrPrev_reg) pendPwr_reg <= 1'b1;
      if (take && grantSrc == SRC_TICK) pendTick_reg <= 1'b0;
      if (tickEv) pendTick_reg <= 1'b1;
      if (take && grantSrc == SRC_TRAP) pendTrap_reg <= 1'b0;
      if ((runError && bind_reg[BIND_TRAP]) || (take && grantUnbound && bind_reg[BIND_TRAP]))
        pendTrap_reg <= 1'b1;
    end
  end

  // handshake with the core, one request at a time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PIC_IDLE;
      reqValid <= 1'b0;
      reqSource <= 8'h00;
    end else begin
      unique case (state_reg)
        PIC_IDLE: begin
          if (grantAny && !grantUnbound) begin
            state_reg <= PIC_OFFER;
            reqValid <= 1'b1;
            reqSource <= grantSrc;
          end
        end
        PIC_OFFER: begin
          if (reqAck) begin
            state_reg <= PIC_BUSY;
            reqValid <= 1'b0;
          end
        end
        PIC_BUSY: begin
          if (reqDone) state_reg <= PIC_IDLE;
        end
      endcase
    end
  end

  // error reporting outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      errShow <= 1'b0;
      errLed <= 1'b0;
      cpuHalt <= 1'b0;
    end else begin
      if (runError) begin
        errShow <= 1'b1;
        errLed <= !bind_reg[BIND_TRAP];
        cpuHalt <= !bind_reg[BIND_TRAP];
      end else if (hit(bus, REG_ERR)) begin
        errShow <= 1'b0;
        errLed <= 1'b0;
        cpuHalt <= 1'b0;
      end
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg <= STAT_RST;
      irq <= 1'b0;
    end else begin
      logic [3:0] setv, nxt;
      setv = '0;
      setv[ST_REQ] = state_reg == PIC_IDLE && grantAny && !grantUnbound;
      setv[ST_TRAP] = runError || (state_reg == PIC_IDLE && grantAny && grantUnbound);
      setv[ST_TICKLOST] = tickEv && pendTick_reg;
      setv[ST_PWR] = !pwrS2_reg && pwrPrev_reg;
      nxt = (hit(bus, REG_STAT) ? stat_reg & ~bus.wdata[3:0] : stat_reg) | setv;
      stat_reg <= nxt;
      irq <= |(nxt & mask_reg);
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdData_next = 16'h0000;
    unique case (bus.addr)
      REG_INCFG: rdData_next = {8'h00, inCfg_reg};
      REG_FUNC: rdData_next = {8'h00, pinFunc};
      REG_TICK: rdData_next = tickMs_reg;
      REG_BIND: rdData_next = {7'h00, bind_reg};
      REG_STAT: rdData_next = {12'h000, stat_reg};
      REG_MASK: rdData_next = {12'h000, mask_reg};
      REG_ERR: rdData_next = {13'h0000, cpuHalt, errLed, errShow};
      default: rdData_next = 16'h0000;
    endcase
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rdData <= 16'h0000;
    else rdData <= bus.rd ? rdData_next : 16'h0000;
  end
endmodule

// ---- verif/pic_interrupt_controller_sva.sv ----
// port assertions for the interrupt controller
`timescale 1ns/1ns
module pic_interrupt_controller_sva
  import pic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port and events
  input wire pic_bus_s bus,
  input wire logic powerLossN,
  input wire logic runError,
  // core handshake
  input wire logic reqValid,
  input wire logic [7:0] reqSource,
  input wire logic reqAck,
  input wire logic reqDone,
  // function select and error display
  input wire pic_func_s pinFunc,
  input wire logic errShow,
  input wire logic errLed,
  input wire logic cpuHalt
);
  logic [3:0] enReg;
  logic [15:0] bindReg;
  logic busyReg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow of enable and binding registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enReg <= 4'h0;
      bindReg <= 16'h0000;
    end else if (bus.wr && bus.addr == REG_INCFG) begin
      enReg <= bus.wdata[3:0];
    end else if (bus.wr && bus.addr == REG_BIND) begin
      bindReg <= bus.wdata;
    end
  end
  // handler running between ack and done
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busyReg <= 1'b0;
    end else if (reqValid && reqAck) begin
      busyReg <= 1'b1;
    end else if (reqDone) begin
      busyReg <= 1'b0;
    end
  end
  property p_hold;
    reqValid && !reqAck |=> reqValid && $stable(reqSource);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped or changed");
  property p_ack;
    reqValid && reqAck |=> !reqValid;
  endproperty
  a_ack: assert property (p_ack) else $error("request stays after ack");
  property p_single;
    busyReg |-> !reqValid;
  endproperty
  a_single: assert property (p_single) else $error("request while handler runs");
  property p_excl;
    ((pinFunc.quadEn | pinFunc.measEn) & enReg & $past(enReg, 2)) == 4'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("interrupt pin keeps other role");
  property p_meas;
    (pinFunc.quadEn & ~pinFunc.measEn) == 4'h0;
  endproperty
  a_meas: assert property (p_meas) else $error("counting without measuring");
  property p_trap;
    runError && bindReg[BIND_TRAP] |-> ##[1:4] errShow;
  endproperty
  a_trap: assert property (p_trap) else $error("trapped error not shown");
  property p_nohalt;
    runError && bindReg[BIND_TRAP] && !cpuHalt && !errLed |=> (!cpuHalt && !errLed) [*4];
  endproperty
  a_nohalt: assert property (p_nohalt) else $error("halt on trapped error");
  property p_pwr;
    $fell(powerLossN) && bindReg[BIND_PWR] && !busyReg && !reqValid
      |-> ##[1:8] (reqValid && reqSource == SRC_PWR);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power loss not requested");
endmodule
bind pic_interrupt_controller pic_interrupt_controller_sva chk (.mclk(mclk),
  .sys_rst(sys_rst), .bus(bus), .powerLossN(powerLossN), .runError(runError),
  .reqValid(reqValid), .reqSource(reqSource), .reqAck(reqAck), .reqDone(reqDone),
  .pinFunc(pinFunc), .errShow(errShow), .errLed(errLed), .cpuHalt(cpuHalt));

// ---- verif/pic_core_model.sv ----
// processor core model taking handler requests
`timescale 1ns/1ns
module pic_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // handshake
  input wire logic reqValid,
  output logic reqAck,
  output logic reqDone
);
  int unsigned w;
  initial begin
    reqAck = 1'b0;
    reqDone = 1'b0;
    forever begin
      @(posedge mclk);
      if (reqValid === 1'b1 && !sys_rst) begin
        w = $urandom_range(3);
        repeat (w) @(posedge mclk);
        reqAck <= 1'b1;
        @(posedge mclk);
        reqAck <= 1'b0;
        w = $urandom_range(6, 1);
        repeat (w) @(posedge mclk);
        reqDone <= 1'b1;
        @(posedge mclk);
        reqDone <= 1'b0;
      end
    end
  end
endmodule

// ---- verif/pic_interrupt_controller_tb.sv ----
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module pic_interrupt_controller_tb;
  import pic_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  pic_bus_s bus = '0;
  logic [3:0] pinIn = 4'h0;
  logic powerLossN = 1'b1;
  logic runError = 1'b0;
  logic [1:0] cntMatch = 2'b00;
  logic [15:0] rdData;
  logic [7:0] reqSource;
  logic reqValid, reqAck, reqDone, errShow, errLed, cpuHalt, irq;
  pic_func_s pinFunc;
  logic [7:0] expQ[$];
  logic [3:0] pol;
  int num_errors = 0;
  int check_count = 0;
  always #5 mclk = ~mclk;
  pic_interrupt_controller uut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdData(rdData),
    .pinIn(pinIn), .powerLossN(powerLossN), .runError(runError), .cntMatch(cntMatch),
    .reqValid(reqValid), .reqSource(reqSource), .reqAck(reqAck), .reqDone(reqDone),
    .pinFunc(pinFunc), .errShow(errShow), .errLed(errLed), .cpuHalt(cpuHalt), .irq(irq));
  pic_core_model core (.mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqAck(reqAck), .reqDone(reqDone));
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp, string what);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(what, rdData, exp);
  endtask
  task automatic pulse(logic [3:0] m, logic [1:0] c, logic e);
    @(posedge mclk);
    pinIn <= pinIn ^ m;
    cntMatch <= c;
    runError <= e;
    @(posedge mclk);
    cntMatch <= 2'b00;
    runError <= 1'b0;
    @(posedge mclk);
    pinIn <= pinIn ^ m;
  endtask
  task automatic settle();
    for (int n = 0; n < 400 && expQ.size() != 0; n++) @(posedge mclk);
    repeat (12) @(posedge mclk);
    chk("pending", 16'(expQ.size()), 16'h0000);
  endtask
  task automatic later(string what, logic [15:0] exp);
    repeat (3) @(posedge mclk);
    #1 chk(what, (what == "irq") ? {15'h0000, irq} : {8'h00, pinFunc}, exp);
  endtask
  // accepted requests against the noted order
  always @(posedge mclk) begin
    if (reqValid === 1'b1 && reqAck === 1'b1) begin
      if (expQ.size() == 0)
        chk("extra", {8'h00, reqSource}, 16'hFFFF);
      else
        chk("source", {8'h00, reqSource}, {8'h00, expQ.pop_front()});
    end
  end
  initial begin
    // whole scenario needs a few hundred cycles, allow ample margin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(57654));
    pol = 4'($urandom());
    pinIn <= ~pol;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_TICK, TICK_RST, "tick");
    rd(REG_STAT, {12'h000, STAT_RST}, "status");
    rd(4'hF, 16'h0000, "unmapped");
    wr(REG_TICK, 16'h000F);
    rd(REG_TICK, 16'h000F, "tick");
    wr(REG_BIND, 16'h000F);
    wr(REG_INCFG, {8'h00, pol, 4'hF});
    for (int i = 0; i < 4; i++) begin
      expQ.push_back(SRC_IN3 + 8'(i));
      pulse(4'b0001 << i, 2'b00, 1'b0);
      settle();
    end
    expQ = '{SRC_IN3, SRC_IN3 + 8'h01, SRC_IN3 + 8'h02, SRC_IN3 + 8'h03};
    pulse(4'hF, 2'b00, 1'b0);
    settle();
    wr(REG_INCFG, 16'h0000);
    wr(REG_CMD, 16'h0001);
    later("func", 16'h0033);
    wr(REG_CMD, 16'h000C);
    later("func", 16'h0003);
    wr(REG_CMD, 16'h003C);
    later("func", 16'h000F);
    wr(REG_INCFG, 16'h0001);
    later("func", 16'h000E);
    wr(REG_CMD, 16'h0002);
    later("func", 16'h00CE);
    wr(REG_BIND, 16'h0180);
    expQ.push_back(SRC_CNT1 + 8'h01);
    pulse(4'h0, 2'b11, 1'b0);
    settle();
    wr(REG_BIND, 16'h0010);
    expQ.push_back(SRC_PWR);
    @(posedge mclk);
    powerLossN <= 1'b0;
    settle();
    powerLossN <= 1'b1;
    rd(REG_STAT, 16'h0009, "status");
    wr(REG_MASK, 16'hFFFF);
    later("irq", 16'h0001);
    wr(REG_MASK, 16'h0000);
    later("irq", 16'h0000);
    wr(REG_MASK, 16'h000F);
    wr(REG_STAT, 16'h000F);
    later("irq", 16'h0000);
    wr(REG_BIND, 16'h0040);
    wr(REG_ERR, 16'h0001);
    expQ.push_back(SRC_TRAP);
    pulse(4'h0, 2'b00, 1'b1);
    settle();
    chk("halt", {13'h0000, errShow, cpuHalt, errLed}, 16'h0004);
    expQ.push_back(SRC_TRAP);
    pulse(4'h1, 2'b00, 1'b0);
    settle();
    give_verdict();
  end
endmodule
